/* File: pkg/scpl_pkg.sv */
// shared constants and types for the serial packet link block
package scpl_pkg;

	// ==========================================================
	// header byte field positions
	localparam int HDR_READY_BIT = 6;
	localparam int HDR_CHANNEL_BIT = 5;
	localparam int HDR_LAST_BIT = 4;
	localparam int HDR_FIRST_BIT = 3;
	localparam int HDR_PENDING_BIT = 2;
	localparam int HDR_FAULT_BIT = 1;

	// ==========================================================
	// sizes
	localparam int MAX_PAYLOAD = 4096;
	localparam int LEN_FIELD_W = 16;
	localparam int SYNC_STAGES = 2;

	// ==========================================================
	// values after reset
	localparam logic [7:0] TX_SHIFT_RESET = 8'h00;
	localparam logic [2:0] BIT_COUNT_RESET = 3'h0;
	localparam logic [31:0] READY_TIMER_RESET = 32'h0000_0000;

	// ==========================================================
	// timing
	localparam longint CLOCK_HZ = 125_000_000;
	localparam longint READY_LIMIT_S = 5;
	localparam longint READY_LIMIT_CYCLES = READY_LIMIT_S * CLOCK_HZ;

	// ==========================================================
	// byte position within a packet
	typedef enum logic [1:0] {
		PH_HEADER,
		PH_LEN_HIGH,
		PH_LEN_LOW,
		PH_PAYLOAD
	} scpl_phase_t;

endpackage

/* File: logic/scpl_sync.sv */
// two-stage synchroniser for independent level and toggle signals
`timescale 1ns/10ps
module scpl_sync #(
	parameter int W = 1
) (
	// clock and reset of the receiving domain
	input wire logic clock,
	input wire logic rst_n,
	// signals from the other domain, and their synchronised copies
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] firstStage;

	// the first stage feeds only the second stage
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			firstStage <= '0;
			q <= '0;
		end else begin
			firstStage <= d;
			q <= firstStage;
		end
	end

endmodule

/* File: logic/scpl_link_core.sv */
// module end of the packetised serial CPU link, with receive and transmit buffers
// What this block does
// - transmit on falling edge, sample on rising
// - host strobe marks each byte; packets are framed by byte count
// - separate lines for each direction, simultaneous
// - first byte of every packet is header
// - two length bytes follow, high byte first
// - payload at most 4096 bytes
// - fixed header bit positions for all flags
// - payload only when pending and both ready
// - module ready within five seconds of reset
// - channel bit selects command or extended
// - first and last marks carry segmentation
// - module flags faults, ignores host fault bit
// - separate 4096-byte receive and transmit buffers
// - one channel per packet, never mixed
`timescale 1ns/10ps
module scpl_link_core
	import scpl_pkg::*;
#(
	parameter int DEPTH = MAX_PAYLOAD,
	parameter int AW = $clog2(DEPTH),
	parameter int CW = AW + 1,
	parameter int unsigned READY_CYCLES = 32'(READY_LIMIT_CYCLES)
) (
	// system
	input wire logic clock,
	input wire logic rst_n,
	// serial link, clocked by the host
	input wire logic serialClk,
	input wire logic byteFrameStrobe,
	input wire logic hostToModuleLine,
	output logic moduleToHostLine,
	// control and status
	input wire logic appReady,
	output logic moduleReady,
	output logic faultFlag,
	// received packet
	output logic rxValid,
	output logic rxChannel,
	output logic rxFirst,
	output logic rxLast,
	output logic [CW-1:0] rxLength,
	input wire logic [AW-1:0] rxReadAddr,
	output logic [7:0] rxReadData,
	input wire logic rxRelease,
	// packet to send
	input wire logic txWriteEn,
	input wire logic [AW-1:0] txWriteAddr,
	input wire logic [7:0] txWriteData,
	input wire logic [CW-1:0] txLength,
	input wire logic txChannel,
	input wire logic txFirst,
	input wire logic txLast,
	input wire logic txSend,
	output logic txBusy
);

	// ==========================================================
	// storage: one buffer per direction
	logic [7:0] rxMem [DEPTH];
	logic [7:0] txMem [DEPTH];

	// ==========================================================
	// core-domain state
	logic rxTake;
	logic txPut;
	logic crCore;
	logic [31:0] readyTimer;
	logic timerDone;
	logic [CW-1:0] txLenCore;
	logic txChanCore;
	logic txFirstCore;
	logic txLastCore;
	logic rxPutSync;
	logic txDoneSync;

	// ==========================================================
	// link-domain state
	logic [2:0] bitCnt;
	logic framed;
	logic [6:0] rxShift;
	scpl_phase_t phase;
	logic [7:0] lenHigh;
	logic controllerSideReady;
	logic payloadPendingIn;
	logic channelKindBit;
	logic hostFirst;
	logic hostLast;
	logic readySnap;
	logic pendSnap;
	logic inActive;
	logic outActive;
	logic [CW-1:0] inLen;
	logic [CW-1:0] outLen;
	logic [CW-1:0] span;
	logic [CW-1:0] byteIdx;
	logic [7:0] txShift;
	logic faultLink;
	logic rxPut;
	logic txDone;
	logic rxTakeSync;
	logic txPutSync;
	logic crCoreSync;

	// ==========================================================
	// link-domain decode
	logic [7:0] byteIn;
	logic byteDone;
	logic [15:0] lenFull;
	logic lenOk;
	logic nextIn;
	logic nextOut;
	logic [CW-1:0] nextInLen;
	logic [CW-1:0] nextOutLen;
	logic [CW-1:0] nextSpan;
	logic [CW-1:0] idxNext;
	logic lastPayload;
	logic moduleSideReady;
	logic pendNow;
	logic [7:0] queryHeaderByte;
	logic [15:0] ownLen;
	logic [7:0] nextTxByte;
	logic framingBad;

	function automatic logic [7:0] payloadByte(input logic act, input logic [CW-1:0] len,
		input logic [CW-1:0] idx);
		// filler zeros once our own payload is shorter than the host's
		payloadByte = (act && idx < len) ? txMem[idx[AW-1:0]] : 8'h00;
	endfunction

	function automatic logic [CW-1:0] maxLen(input logic [CW-1:0] a, input logic [CW-1:0] b);
		maxLen = (a > b) ? a : b;
	endfunction

	// ==========================================================
	// crossings
	scpl_sync #(.W(3)) linkToCore (
		.clock(clock),
		.rst_n(rst_n),
		.d({rxPut, txDone, faultLink}),
		.q({rxPutSync, txDoneSync, faultFlag})
	);

	scpl_sync #(.W(3)) coreToLink (
		.clock(serialClk),
		.rst_n(rst_n),
		.d({rxTake, txPut, crCore}),
		.q({rxTakeSync, txPutSync, crCoreSync})
	);

	// ==========================================================
	// byte framing and header construction
	assign byteIn = {rxShift, hostToModuleLine};
	assign byteDone = framed && !byteFrameStrobe && bitCnt == 3'h7;
	// a strobe inside a byte, or none at a byte boundary, breaks framing
	assign framingBad = framed && (byteFrameStrobe != (bitCnt == 3'h0));
	assign lenFull = {lenHigh, byteIn};
	assign lenOk = lenFull <= 16'(DEPTH);
	assign nextIn = payloadPendingIn && controllerSideReady && readySnap && lenOk;
	assign nextOut = pendSnap && readySnap && controllerSideReady;
	assign nextInLen = nextIn ? CW'(lenFull) : '0;
	assign nextOutLen = nextOut ? txLenCore : '0;
	assign nextSpan = maxLen(nextInLen, nextOutLen);
	assign idxNext = CW'(byteIdx + 1'b1);
	assign lastPayload = byteIdx == CW'(span - 1'b1);
	// the buffer must be free before the host may send into it; a payload
	// that ends on this byte fills it, so the next header must not offer it
	assign moduleSideReady = crCoreSync && rxPut == rxTakeSync &&
		!(phase == PH_PAYLOAD && lastPayload && inActive);
	// a transfer that ends on this byte is no longer pending in the next header
	assign pendNow = txPutSync != txDone &&
		!(phase == PH_PAYLOAD && lastPayload && outActive) &&
		!(phase == PH_LEN_LOW && nextSpan == '0 && nextOut);
	assign ownLen = pendSnap ? LEN_FIELD_W'(txLenCore) : '0;

	always_comb begin
		queryHeaderByte = 8'h00;
		queryHeaderByte[HDR_READY_BIT] = moduleSideReady;
		queryHeaderByte[HDR_CHANNEL_BIT] = pendNow && txChanCore;
		queryHeaderByte[HDR_LAST_BIT] = pendNow && txLastCore;
		queryHeaderByte[HDR_FIRST_BIT] = pendNow && txFirstCore;
		queryHeaderByte[HDR_PENDING_BIT] = pendNow;
		queryHeaderByte[HDR_FAULT_BIT] = faultLink;
	end

	// next byte to present once the current one completes
	always_comb begin
		case (phase)
			PH_HEADER: nextTxByte = ownLen[15:8];
			PH_LEN_HIGH: nextTxByte = ownLen[7:0];
			PH_LEN_LOW: begin
				if (nextSpan == '0) begin
					nextTxByte = queryHeaderByte;
				end else begin
					nextTxByte = payloadByte(nextOut, nextOutLen, '0);
				end
			end
			PH_PAYLOAD: begin
				if (lastPayload) begin
					nextTxByte = queryHeaderByte;
				end else begin
					nextTxByte = payloadByte(outActive, outLen, idxNext);
				end
			end
			default: nextTxByte = queryHeaderByte;
		endcase
	end

	// ==========================================================
	// link: bit sampling on the rising edge
	always_ff @(posedge serialClk or negedge rst_n) begin
		if (!rst_n) begin
			bitCnt <= BIT_COUNT_RESET;
			framed <= 1'b0;
			rxShift <= 7'h00;
		end else if (byteFrameStrobe) begin
			bitCnt <= 3'h1;
			framed <= 1'b1;
			rxShift <= {6'h00, hostToModuleLine};
		end else if (framed) begin
			bitCnt <= 3'(bitCnt + 1'b1);
			rxShift <= {rxShift[5:0], hostToModuleLine};
		end
	end

	// link: outgoing shift register, reloaded at each byte boundary
	always_ff @(posedge serialClk or negedge rst_n) begin
		if (!rst_n) begin
			txShift <= TX_SHIFT_RESET;
			readySnap <= 1'b0;
			pendSnap <= 1'b0;
		end else if (byteDone) begin
			txShift <= nextTxByte;
			if ((phase == PH_LEN_LOW && nextSpan == '0) || (phase == PH_PAYLOAD && lastPayload)) begin
				// flags sent in the header are the ones the packet obeys
				readySnap <= moduleSideReady;
				pendSnap <= pendNow;
			end
		end else if (framed || byteFrameStrobe) begin
			txShift <= {txShift[6:0], 1'b0};
		end
	end

	// link: data changes only on the falling edge
	always_ff @(negedge serialClk or negedge rst_n) begin
		if (!rst_n) begin
			moduleToHostLine <= 1'b0;
		end else begin
			moduleToHostLine <= txShift[7];
		end
	end

	// link: packet sequencing
	always_ff @(posedge serialClk or negedge rst_n) begin
		if (!rst_n) begin
			phase <= PH_HEADER;
			lenHigh <= 8'h00;
			controllerSideReady <= 1'b0;
			payloadPendingIn <= 1'b0;
			channelKindBit <= 1'b0;
			hostFirst <= 1'b0;
			hostLast <= 1'b0;
			inActive <= 1'b0;
			outActive <= 1'b0;
			inLen <= '0;
			outLen <= '0;
			span <= '0;
			byteIdx <= '0;
			rxPut <= 1'b0;
			txDone <= 1'b0;
		end else if (byteDone) begin
			case (phase)
				PH_HEADER: begin
					// the host fault bit is deliberately not latched
					controllerSideReady <= byteIn[HDR_READY_BIT];
					if (rxPut == rxTakeSync) begin
						// packet fields stay frozen while the core still owns them
						channelKindBit <= byteIn[HDR_CHANNEL_BIT];
						hostLast <= byteIn[HDR_LAST_BIT];
						hostFirst <= byteIn[HDR_FIRST_BIT];
					end
					payloadPendingIn <= byteIn[HDR_PENDING_BIT];
					phase <= PH_LEN_HIGH;
				end
				PH_LEN_HIGH: begin
					lenHigh <= byteIn;
					phase <= PH_LEN_LOW;
				end
				PH_LEN_LOW: begin
					inActive <= nextIn && nextInLen != '0;
					outActive <= nextOut;
					if (rxPut == rxTakeSync) begin
						inLen <= nextInLen;
					end
					outLen <= nextOutLen;
					span <= nextSpan;
					byteIdx <= '0;
					if (nextSpan == '0) begin
						if (nextOut) begin
							txDone <= ~txDone;
						end
						phase <= PH_HEADER;
					end else begin
						phase <= PH_PAYLOAD;
					end
				end
				PH_PAYLOAD: begin
					byteIdx <= idxNext;
					if (lastPayload) begin
						// host clocks the longer payload out in full
						if (inActive) begin
							rxPut <= ~rxPut;
						end
						if (outActive) begin
							txDone <= ~txDone;
						end
						phase <= PH_HEADER;
					end
				end
				default: phase <= PH_HEADER;
			endcase
		end
	end

	// link: receive buffer writes
	always_ff @(posedge serialClk) begin
		if (byteDone && phase == PH_PAYLOAD && inActive && byteIdx < inLen) begin
			rxMem[byteIdx[AW-1:0]] <= byteIn;
		end
	end

	// link: interface faults stay until the module is reset
	always_ff @(posedge serialClk or negedge rst_n) begin
		if (!rst_n) begin
			faultLink <= 1'b0;
		end else if (framingBad) begin
			faultLink <= 1'b1;
		end else if (byteDone && phase == PH_LEN_LOW && !lenOk &&
			payloadPendingIn && controllerSideReady && readySnap) begin
			faultLink <= 1'b1;
		end
	end

	// ==========================================================
	// core: readiness deadline after reset
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			readyTimer <= READY_TIMER_RESET;
			timerDone <= 1'b0;
		end else if (!timerDone) begin
			readyTimer <= readyTimer + 32'h0000_0001;
			timerDone <= readyTimer >= READY_CYCLES - 32'h0000_0001;
		end
	end

	// the deadline forces readiness even if the application is slow
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			crCore <= 1'b0;
			moduleReady <= 1'b0;
		end else begin
			crCore <= appReady || timerDone;
			moduleReady <= crCore;
		end
	end

	// ==========================================================
	// core: received packet hand-off
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rxValid <= 1'b0;
			rxTake <= 1'b0;
			rxChannel <= 1'b0;
			rxFirst <= 1'b0;
			rxLast <= 1'b0;
			rxLength <= '0;
		end else if (rxValid) begin
			if (rxRelease) begin
				rxValid <= 1'b0;
				rxTake <= ~rxTake;
			end
		end else if (rxPutSync != rxTake) begin
			// link fields are frozen until the take toggle reaches it
			rxValid <= 1'b1;
			rxChannel <= channelKindBit;
			rxFirst <= hostFirst;
			rxLast <= hostLast;
			rxLength <= inLen;
		end
	end

	always_ff @(posedge clock) begin
		rxReadData <= rxMem[rxReadAddr];
	end

	// ==========================================================
	// core: transmit buffer and hand-off
	always_ff @(posedge clock) begin
		if (txWriteEn && !txBusy) begin
			txMem[txWriteAddr] <= txWriteData;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			txBusy <= 1'b0;
			txPut <= 1'b0;
			txLenCore <= '0;
			txChanCore <= 1'b0;
			txFirstCore <= 1'b0;
			txLastCore <= 1'b0;
		end else if (!txBusy) begin
			if (txSend && txLength <= CW'(DEPTH)) begin
				txBusy <= 1'b1;
				txPut <= ~txPut;
				txLenCore <= txLength;
				txChanCore <= txChannel;
				txFirstCore <= txFirst;
				txLastCore <= txLast;
			end
		end else if (txDoneSync == txPut) begin
			txBusy <= 1'b0;
		end
	end

endmodule

/* File: tb/scpl_link_monitor.sv */
// checker bound to the serial packet link core
`timescale 1ns/10ps
module scpl_link_monitor #(
	parameter int CW = 13,
	parameter int unsigned READY_CYCLES = 200
) (
	// system
	input wire logic clock,
	input wire logic rst_n,
	// user side
	input wire logic appReady,
	input wire logic moduleReady,
	input wire logic faultFlag,
	input wire logic rxValid,
	input wire logic rxRelease,
	input wire logic [CW-1:0] rxLength,
	input wire logic txSend,
	input wire logic txBusy,
	input wire logic [CW-1:0] txLength
);
	// =====
	// cycles since reset, saturating so it never wraps
	int unsigned upCount;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			upCount <= 0;
		end else if (upCount < READY_CYCLES + 8) begin
			upCount <= upCount + 1;
		end
	end
	default clocking @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	// =====
	// properties
	property p_deadline;
		upCount > READY_CYCLES + 3 |-> moduleReady;
	endproperty
	a_deadline: assert property (p_deadline)
		else $error("ready late");
	property p_follow;
		appReady[*4] |-> moduleReady;
	endproperty
	a_follow: assert property (p_follow)
		else $error("ready not following");
	property p_sticky;
		faultFlag |=> faultFlag;
	endproperty
	a_sticky: assert property (p_sticky)
		else $error("fault cleared");
	property p_send;
		txSend && !txBusy && txLength <= 13'h1000 |=> txBusy;
	endproperty
	a_send: assert property (p_send)
		else $error("send not taken");
	property p_idle;
		!txBusy && !txSend |=> !txBusy;
	endproperty
	a_idle: assert property (p_idle)
		else $error("busy without send");
	property p_release;
		rxValid && rxRelease |=> !rxValid;
	endproperty
	a_release: assert property (p_release)
		else $error("release ignored");
	property p_hold;
		rxValid && !rxRelease |=> rxValid && $stable(rxLength);
	endproperty
	a_hold: assert property (p_hold)
		else $error("rx packet not held");
	property p_max;
		rxValid |-> rxLength <= 13'h1000;
	endproperty
	a_max: assert property (p_max)
		else $error("rx length too big");
	c_rx: cover property ($rose(rxValid));
	c_tx: cover property ($fell(txBusy));
	c_fault: cover property ($rose(faultFlag));
endmodule
bind scpl_link_core scpl_link_monitor #(.CW(CW), .READY_CYCLES(READY_CYCLES)) mon (
	.clock(clock), .rst_n(rst_n), .appReady(appReady), .moduleReady(moduleReady),
	.faultFlag(faultFlag), .rxValid(rxValid), .rxRelease(rxRelease),
	.rxLength(rxLength), .txSend(txSend), .txBusy(txBusy), .txLength(txLength)
);

/* File: tb/scpl_host_model.sv */
// host master model that clocks packets over the serial link
`timescale 1ns/10ps
module scpl_host_model (
	// link pins
	output logic serialClk,
	output logic byteFrameStrobe,
	output logic hostToModuleLine,
	input wire logic moduleToHostLine
);
	bit slow = 1'b0;
	logic [7:0] txq[$];
	logic [7:0] rxq[$];
	initial begin
		serialClk = 1'b0;
		byteFrameStrobe = 1'b0;
		hostToModuleLine = 1'b0;
	end
	// =====
	// one byte each way; with slow set the clock stands still between bytes
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			byteFrameStrobe = (i == 7);
			hostToModuleLine = tx[i];
			#3 serialClk = 1'b1;
			rx[i] = moduleToHostLine;
			#3 serialClk = 1'b0;
		end
		byteFrameStrobe = 1'b0;
		if (slow) begin
			hostToModuleLine = ~tx[0];
			#29;
		end
	endtask
	// =====
	// one packet: header, length, then the longer payload of both sides
	task automatic packet(input logic [7:0] hdr, input int len,
		output logic [7:0] mHdr, output logic [15:0] mLen);
		logic [7:0] b, hi, lo;
		int inLen, outLen;
		xfer(hdr, mHdr);
		xfer(8'(len >> 8), hi);
		xfer(8'(len), lo);
		mLen = {hi, lo};
		inLen = (hdr[2] && hdr[6] && mHdr[6] && len <= 4096) ? len : 0;
		outLen = (mHdr[2] && mHdr[6] && hdr[6]) ? int'(mLen) : 0;
		rxq = {};
		for (int i = 0; i < inLen || i < outLen; i++) begin
			xfer((i < inLen) ? txq[i] : 8'h00, b);
			if (i < outLen) begin
				rxq.push_back(b);
			end
		end
	endtask
endmodule

/* File: tb/scpl_link_core_tb_top.sv */
// self-checking bench for the serial packet link core
`timescale 1ns/10ps
module scpl_link_core_tb_top;
	localparam int RC = 200;
	logic clock, rst_n, appReady, txWriteEn, txSend, txChannel, txFirst, txLast;
	logic moduleReady, faultFlag, rxValid, rxChannel, rxFirst, rxLast, txBusy;
	logic serialClk, byteFrameStrobe, hostToModuleLine, moduleToHostLine;
	logic rxRelease = 1'b0;
	logic [11:0] rxReadAddr = 12'h0;
	logic [11:0] txWriteAddr;
	logic [12:0] rxLength, txLength;
	logic [7:0] rxReadData, txWriteData, mh;
	logic [15:0] ml;
	logic [15:0] expQ[$];
	logic [7:0] txExp[$];
	int lens[4] = '{1, 4096, 9, 2};
	int fail_count = 0;
	int num_checks = 0;
	int cycles = 0;
	scpl_link_core #(.READY_CYCLES(RC)) dut (
		.clock(clock), .rst_n(rst_n), .serialClk(serialClk),
		.byteFrameStrobe(byteFrameStrobe), .hostToModuleLine(hostToModuleLine),
		.moduleToHostLine(moduleToHostLine), .appReady(appReady),
		.moduleReady(moduleReady), .faultFlag(faultFlag), .rxValid(rxValid),
		.rxChannel(rxChannel), .rxFirst(rxFirst), .rxLast(rxLast), .rxLength(rxLength),
		.rxReadAddr(rxReadAddr), .rxReadData(rxReadData), .rxRelease(rxRelease),
		.txWriteEn(txWriteEn), .txWriteAddr(txWriteAddr), .txWriteData(txWriteData),
		.txLength(txLength), .txChannel(txChannel), .txFirst(txFirst), .txLast(txLast),
		.txSend(txSend), .txBusy(txBusy));
	scpl_host_model host (.serialClk(serialClk), .byteFrameStrobe(byteFrameStrobe),
		.hostToModuleLine(hostToModuleLine), .moduleToHostLine(moduleToHostLine));
	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		num_checks++;
		if (seen !== want) begin
			fail_count++;
			$display("BAD %0t seen %h want %h", $time, seen, want);
		end
	endtask
	task automatic print_verdict();
		if (fail_count == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic load_host(input logic [2:0] f, input int n);
		host.txq = {};
		expQ.push_back(16'(f));
		expQ.push_back(16'(n));
		for (int i = 0; i < n; i++) begin
			host.txq.push_back(8'($urandom));
			expQ.push_back(16'(host.txq[i]));
		end
	endtask
	// idle headers until the receive buffer is offered again
	task automatic await_ready();
		int n = 0;
		do begin
			host.packet(8'h40, 0, mh, ml);
			n++;
		end while (mh[6] !== 1'b1 && n < 400);
		check(mh[6], 1'b1);
		@(posedge clock);
	endtask
	// =====
	// clock, timeout and rx watcher
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			fail_count++;
			print_verdict();
		end
	end
	initial begin
		logic [15:0] e, n;
		forever begin
			@(posedge clock);
			if (rxValid === 1'b1) begin
				e = expQ.pop_front();
				n = expQ.pop_front();
				check({rxChannel, rxFirst, rxLast}, e);
				check(rxLength, n);
				for (int i = 0; i <= n; i++) begin
					rxReadAddr <= 12'(i);
					@(posedge clock);
					if (i > 0) check(rxReadData, expQ.pop_front());
				end
				rxRelease <= 1'b1;
				@(posedge clock);
				rxRelease <= 1'b0;
			end
		end
	end
	// =====
	// main sequence
	initial begin
		logic [2:0] f;
		int n;
		void'($urandom(32'h43561062));
		{rst_n, appReady, txWriteEn, txSend, txChannel, txFirst, txLast} = '0;
		{txWriteAddr, txWriteData, txLength} = '0;
		repeat (10) @(posedge clock);
		rst_n <= 1'b1;
		host.packet(8'h40, 0, mh, ml);
		check(mh, 8'h00);
		check(ml, 16'h0);
		check(moduleReady, 1'b0);
		repeat (RC) @(posedge clock);
		host.packet(8'h40, 0, mh, ml);
		host.packet(8'h40, 0, mh, ml);
		check(mh, 8'h40);
		check(moduleReady, 1'b1);
		for (int k = 0; k < 4; k++) begin
			f = {k[0], k[1], k[1] ^ k[0]};
			n = lens[k];
			host.slow = (k == 3);
			load_host(f, n);
			host.packet({2'b01, f[2], f[0], f[1], 1'b1, k == 2, 1'b0}, n, mh, ml);
			await_ready();
			check(faultFlag, 1'b0);
		end
		appReady <= 1'b1;
		for (int k = 0; k < 2; k++) begin
			n = 3 + k * 4;
			f = 3'($urandom);
			txExp = {};
			for (int i = 0; i < n; i++) begin
				txExp.push_back(8'($urandom));
				txWriteEn <= 1'b1;
				txWriteAddr <= 12'(i);
				txWriteData <= txExp[i];
				@(posedge clock);
			end
			txWriteEn <= 1'b0;
			{txChannel, txFirst, txLast} <= f;
			txLength <= 13'(n);
			txSend <= 1'b1;
			@(posedge clock);
			txSend <= 1'b0;
			@(posedge clock);
			check(txBusy, 1'b1);
			// host not ready: length shown but no payload may flow
			host.packet(8'h00, 0, mh, ml);
			host.packet(8'h00, 0, mh, ml);
			check(mh, {2'b01, f[2], f[0], f[1], 3'h4});
			check(ml, 16'(n));
			check(16'(host.rxq.size()), 16'h0);
			load_host(f, k + 1);
			host.packet({2'b01, f[2], f[0], f[1], 3'h4}, k + 1, mh, ml);
			check(16'(host.rxq.size()), 16'(n));
			foreach (txExp[i]) check(host.rxq[i], txExp[i]);
			await_ready();
			repeat (4) @(posedge clock);
			check(txBusy, 1'b0);
		end
		host.packet(8'h44, 4097, mh, ml);
		host.packet(8'h40, 0, mh, ml);
		host.packet(8'h40, 0, mh, ml);
		check(faultFlag, 1'b1);
		check(mh[1], 1'b1);
		print_verdict();
	end
endmodule
